// >>> hw/nfc_converter.sv
`timescale 1ns/100ps

// Overview of operation
// - Unsigned to wider integer zero-fills the added upper bits.
// - Unsigned to equal-width signed without saturation passes the bits.
// - Saturated unsigned to equal-width signed clamps to the signed maximum.
// - Signed to wider signed copies the sign bit upward.
// - Signed to wider unsigned without saturation sign-extends.
// - Saturated signed to wider unsigned turns negatives into zero.
// - Narrowing without saturation keeps the low destination bits only.
// - Saturated narrowing clamps out-of-range values to minimum or maximum.
// - Integer to single float is exact for magnitudes within 24 bits.
// - Wider integer magnitudes round to nearest, ties to even.
// - Double to single keeps specials; double denormals become signed zero.
// - Upper half of a double-to-single result is undefined.
// - Single to double is exact; denormals become normal doubles.

module nfc_converter
  import nfc_pkg::*;
(
  // Clock and reset
  input  wire logic     i_clock,
  input  wire logic     i_rst_n,
  // Request from issue logic
  input  wire nfc_req_t i_req,
  // Converted result
  output nfc_rsp_t      o_rsp
);

  // ==========================================================================
  // Integer helpers
  // ==========================================================================
  function automatic int unsigned fmt_width(input nfc_fmt_t f);
    unique case (f)
      FMT_UB, FMT_B: return 8;
      FMT_UW, FMT_W: return 16;
      FMT_UD, FMT_D: return 32;
      default:       return 64;
    endcase
  endfunction : fmt_width

  function automatic logic fmt_signed(input nfc_fmt_t f);
    return (f == FMT_B) || (f == FMT_W) || (f == FMT_D) || (f == FMT_Q);
  endfunction : fmt_signed

  function automatic logic fmt_int(input nfc_fmt_t f);
    return (f != FMT_F) && (f != FMT_DF);
  endfunction : fmt_int

  // Reads a packed integer as its true value: zero or sign extension
  function automatic logic signed [64:0] int_value(input logic [63:0] d,
                                                   input nfc_fmt_t    f);
    unique case (f)
      FMT_UB:  return {57'h0, d[7:0]};
      FMT_B:   return {{57{d[7]}}, d[7:0]};
      FMT_UW:  return {49'h0, d[15:0]};
      FMT_W:   return {{49{d[15]}}, d[15:0]};
      FMT_UD:  return {33'h0, d[31:0]};
      FMT_D:   return {{33{d[31]}}, d[31:0]};
      FMT_UQ:  return {1'b0, d};
      FMT_Q:   return {d[63], d};
      default: return '0;
    endcase
  endfunction : int_value

  function automatic logic signed [64:0] dst_max(input nfc_fmt_t f);
    int unsigned w;
    w = fmt_width(f) - (fmt_signed(f) ? 1 : 0);
    return (65'h1 << w) - 65'h1;
  endfunction : dst_max

  function automatic logic signed [64:0] dst_min(input nfc_fmt_t f);
    if (fmt_signed(f))
    begin
      return -(65'sh1 << (fmt_width(f) - 1));
    end
    return '0;
  endfunction : dst_min

  // ==========================================================================
  // Integer to integer
  // ==========================================================================
  logic signed [64:0] src_val;
  logic signed [64:0] lim_hi;
  logic signed [64:0] lim_lo;
  logic signed [64:0] clamped;
  logic signed [64:0] res_ext;
  logic [63:0]        int_res;

  always_comb
  begin
    // Source formats arrive with every value
    src_val = int_value(i_req.data, i_req.src_fmt);
    lim_hi  = dst_max(i_req.dst_fmt);
    lim_lo  = dst_min(i_req.dst_fmt);
    clamped = src_val;
    if (i_req.sat)
    begin
      if (src_val > lim_hi)
      begin
        clamped = lim_hi;
      end
      else if (src_val < lim_lo)
      begin
        clamped = lim_lo;
      end
    end
    // Extension already happened in int_value; re-reading the low bits at
    // the destination width truncates and re-extends in one step
    res_ext = int_value(clamped[63:0], i_req.dst_fmt);
    int_res = res_ext[63:0];
  end

  // ==========================================================================
  // Integer to single float
  // ==========================================================================
  logic        i2f_neg;
  logic [63:0] i2f_mag;
  logic [31:0] i2f_bits;

  always_comb
  begin
    i2f_neg = src_val[64];
    i2f_mag = i2f_neg ? 64'(-src_val) : src_val[63:0];
  end

  nfc_int_to_sf u_int_to_sf
  (
    .i_neg  (i2f_neg),
    .i_mag  (i2f_mag),
    .o_bits (i2f_bits)
  );

  // ==========================================================================
  // Double to single float
  // ==========================================================================
  logic               dn_sign;
  logic [10:0]        dn_exp;
  logic [51:0]        dn_frac;
  logic signed [12:0] dn_te;
  logic [12:0]        dn_sh_wide;
  logic [5:0]         dn_sh;
  logic [63:0]        dn_sig;
  logic [63:0]        dn_part;
  logic [30:0]        dn_base;
  logic [30:0]        d2s_rnd;
  logic [31:0]        d2s_bits;

  always_comb
  begin
    dn_sign    = i_req.data[63];
    dn_exp     = i_req.data[62:52];
    dn_frac    = i_req.data[51:0];
    dn_te      = $signed({2'b00, dn_exp}) - $signed(BIAS_DIFF_S);
    dn_sig     = {11'h0, 1'b1, dn_frac};
    // Below the normal range the shift grows; capping it still leaves a
    // zero result, with the sticky bit set by the significand
    dn_sh_wide = (dn_te >= 13'sh1) ? {7'h0, DF_SF_SHIFT}
                                  : 13'({7'h0, DF_SF_SHIFT} + 13'h1 - dn_te);
    dn_sh      = (dn_sh_wide > {7'h0, SHIFT_CAP}) ? SHIFT_CAP
                                                 : dn_sh_wide[5:0];
    dn_part    = dn_sig >> (dn_sh - 6'h1);
    dn_base    = (dn_te >= 13'sh1) ? {dn_te[7:0], dn_part[23:1]}
                                  : {8'h0, dn_part[23:1]};
    d2s_rnd    = rne_round(dn_base, dn_part[0],
                           |(dn_sig & ((64'h1 << (dn_sh - 6'h1)) - 64'h1)));
    if (dn_exp == DF_EXP_MAX)
    begin
      // Infinity stays infinity, NaN stays NaN with quiet bit set
      if (dn_frac == 52'h0)
      begin
        d2s_bits = {dn_sign, SF_EXP_MAX, 23'h0};
      end
      else
      begin
        d2s_bits = {dn_sign, SF_EXP_MAX, 1'b1, dn_frac[50:29]};
      end
    end
    else if (dn_exp == 11'h000)
    begin
      d2s_bits = {dn_sign, 31'h0};
    end
    else if (dn_te >= $signed(SF_NORM_LIMIT))
    begin
      // A finite double never turns into infinity; too large clamps to
      // the largest finite single of the same sign
      d2s_bits = {dn_sign, SF_FIN_MAX};
    end
    else if (d2s_rnd[30:23] == SF_EXP_MAX)
    begin
      // Rounding carried out of the top finite value
      d2s_bits = {dn_sign, SF_FIN_MAX};
    end
    else
    begin
      d2s_bits = {dn_sign, d2s_rnd};
    end
  end

  // ==========================================================================
  // Single to double float
  // ==========================================================================
  logic        sd_sign;
  logic [7:0]  sd_exp;
  logic [22:0] sd_frac;
  logic [4:0]  sd_lead;
  logic [52:0] sd_norm;
  logic [63:0] s2d_bits;

  always_comb
  begin
    sd_sign = i_req.data[31];
    sd_exp  = i_req.data[30:23];
    sd_frac = i_req.data[22:0];
    sd_lead = 5'h0;
    for (int i = 0; i < SF_FRAC_W; i++)
    begin
      if (sd_frac[i])
      begin
        sd_lead = 5'(i);
      end
    end
    sd_norm = {30'h0, sd_frac} << (DENORM_TOP - {1'b0, sd_lead});
    if (sd_exp == SF_EXP_MAX)
    begin
      s2d_bits = {sd_sign, DF_EXP_MAX, sd_frac, 29'h0};
    end
    else if (sd_exp == 8'h00 && sd_frac == 23'h0)
    begin
      s2d_bits = {sd_sign, 63'h0};
    end
    else if (sd_exp == 8'h00)
    begin
      // Denormal input becomes a normal double, nothing is lost
      s2d_bits = {sd_sign, DENORM_EXP_OFS + {6'h0, sd_lead},
                  sd_norm[51:0]};
    end
    else
    begin
      s2d_bits = {sd_sign, {3'h0, sd_exp} + BIAS_DIFF, sd_frac,
                  29'h0};
    end
  end

  // ==========================================================================
  // Result select and output register
  // ==========================================================================
  logic     sel_int;
  logic     sel_i2f;
  logic     sel_d2s;
  logic     sel_s2d;
  nfc_rsp_t rsp_r;
  nfc_rsp_t rsp_nxt;

  // Exactly one path per supported pair; the rest is flagged, not guessed
  always_comb
  begin
    sel_int = fmt_int(i_req.src_fmt) && fmt_int(i_req.dst_fmt);
    sel_i2f = fmt_int(i_req.src_fmt) && (i_req.dst_fmt == FMT_F);
    sel_d2s = (i_req.src_fmt == FMT_DF) && (i_req.dst_fmt == FMT_F);
    sel_s2d = (i_req.src_fmt == FMT_F) && (i_req.dst_fmt == FMT_DF);
  end

  always_comb
  begin
    rsp_nxt       = RSP_RESET;
    rsp_nxt.valid = i_req.valid;
    if (sel_int)
    begin
      rsp_nxt.data = int_res;
    end
    else if (sel_i2f)
    begin
      rsp_nxt.data = {32'h0, i2f_bits};
    end
    else if (sel_d2s)
    begin
      // Upper half carries no meaning; zero is the cheapest filler
      rsp_nxt.data = {32'h0, d2s_bits};
    end
    else if (sel_s2d)
    begin
      rsp_nxt.data = s2d_bits;
    end
    else
    begin
      // Float to integer, integer to double and same-float pairs are
      // handled elsewhere in the unit
      rsp_nxt.unsup = i_req.valid;
    end
  end

  // One flop stage: each result stands for the cycle after its taking edge
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      rsp_r <= RSP_RESET;
    end
    else
    begin
      rsp_r <= rsp_nxt;
    end
  end

  assign o_rsp = rsp_r;

endmodule : nfc_converter

// >>> hw/nfc_int_to_sf.sv
`timescale 1ns/100ps

module nfc_int_to_sf
  import nfc_pkg::*;
(
  // Integer magnitude and sign
  input  wire logic        i_neg,
  input  wire logic [63:0] i_mag,
  // Single-precision pattern
  output logic      [31:0] o_bits
);

  logic [5:0]  msb;
  logic [63:0] norm;
  logic [7:0]  exp;
  logic [30:0] base;

  // ==========================================================================
  // Normalise and round
  // ==========================================================================
  always_comb
  begin
    msb = 6'h0;
    for (int i = 0; i < 64; i++)
    begin
      if (i_mag[i])
      begin
        msb = 6'(i);
      end
    end
    norm = i_mag << (6'h3F - msb);
    exp  = SF_BIAS + {2'b00, msb};
    base = {exp, norm[62:40]};
    if (i_mag == 64'h0)
    begin
      o_bits = {i_neg, 31'h0};
    end
    else
    begin
      // Magnitudes up to 24 bits leave guard and sticky clear
      o_bits = {i_neg, rne_round(base, norm[39], |norm[38:0])};
    end
  end

endmodule : nfc_int_to_sf

// >>> inc/nfc_pkg.sv
package nfc_pkg;

  // ==========================================================================
  // Formats and carriers
  // ==========================================================================
  typedef enum logic [3:0]
  {
    FMT_UB,
    FMT_B,
    FMT_UW,
    FMT_W,
    FMT_UD,
    FMT_D,
    FMT_UQ,
    FMT_Q,
    FMT_F,
    FMT_DF
  } nfc_fmt_t;

  typedef struct packed
  {
    logic        valid;
    nfc_fmt_t    src_fmt;
    nfc_fmt_t    dst_fmt;
    logic        sat;
    logic [63:0] data;
  } nfc_req_t;

  typedef struct packed
  {
    logic        valid;
    logic        unsup;
    logic [63:0] data;
  } nfc_rsp_t;

  // ==========================================================================
  // Constants
  // ==========================================================================
  localparam nfc_rsp_t    RSP_RESET      = '0;
  localparam int unsigned CONV_LATENCY   = 1;
  localparam logic [7:0]  SF_BIAS        = 8'h7F;
  localparam logic [7:0]  SF_EXP_MAX     = 8'hFF;
  localparam logic [10:0] DF_EXP_MAX     = 11'h07FF;
  localparam logic [10:0] BIAS_DIFF      = 11'h0380;
  localparam logic [12:0] BIAS_DIFF_S    = 13'h0380;
  localparam logic [12:0] SF_NORM_LIMIT  = 13'h00FF;
  localparam logic [30:0] SF_FIN_MAX     = 31'h7F7F_FFFF;
  localparam logic [10:0] DENORM_EXP_OFS = 11'h036A;
  localparam logic [5:0]  DF_SF_SHIFT    = 6'h1D;
  localparam logic [5:0]  SHIFT_CAP      = 6'h37;
  localparam logic [5:0]  DENORM_TOP     = 6'h34;
  localparam int unsigned SF_FRAC_W      = 23;
  localparam int unsigned SF_EXACT_W     = 24;

  // ==========================================================================
  // Shared arithmetic
  // ==========================================================================
  // Round to nearest, ties to even; a carry out of the fraction walks into
  // the exponent, which turns a denormal into a normal and a max into inf
  function automatic logic [30:0] rne_round(input logic [30:0] base,
                                            input logic        guard,
                                            input logic        sticky);
    logic rup;
    rup = guard & (sticky | base[0]);
    return base + {30'h0, rup};
  endfunction : rne_round

endpackage : nfc_pkg

// >>> tb/nfc_converter_assertions.sv
`timescale 1ns/100ps

module nfc_converter_assertions
  import nfc_pkg::*;
(
  // Clock and reset
  input  wire logic     i_clock,
  input  wire logic     i_rst_n,
  // Watched ports
  input  wire nfc_req_t i_req,
  input  wire nfc_rsp_t o_rsp
);
  // =========================================================================
  // Helper
  // =========================================================================
  nfc_req_t prev_r;

  always_ff @(posedge i_clock or negedge i_rst_n)
    if (!i_rst_n)
      prev_r <= '0;
    else
      prev_r <= i_req;

  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  function automatic logic is_op(input nfc_fmt_t s, input nfc_fmt_t d);
    return i_req.valid && i_req.src_fmt == s && i_req.dst_fmt == d;
  endfunction : is_op

  // =========================================================================
  // Checks
  // =========================================================================
  chk_rsp_follows: assert property (i_req.valid |=> o_rsp.valid)
    else $error("response missing");
  chk_rsp_quiet: assert property (!i_req.valid |=> !o_rsp.valid)
    else $error("spurious response");
  chk_zero_fill: assert property (is_op(FMT_UB, FMT_UW)
    |=> o_rsp.data[15:0] == {8'h00, prev_r.data[7:0]})
    else $error("zero fill wrong");
  chk_wrap_equal: assert property (is_op(FMT_UB, FMT_B) && !i_req.sat
    |=> o_rsp.data[7:0] == prev_r.data[7:0])
    else $error("equal width wrap wrong");
  chk_sat_smax: assert property (is_op(FMT_UD, FMT_D) && i_req.sat
    && i_req.data[31] |=> o_rsp.data[31:0] == 32'h7FFF_FFFF)
    else $error("signed max clamp wrong");
  chk_sign_copy: assert property (is_op(FMT_B, FMT_W)
    |=> o_rsp.data[15:0] == {{8{prev_r.data[7]}}, prev_r.data[7:0]})
    else $error("sign extension wrong");
  chk_neg_zero: assert property (is_op(FMT_W, FMT_UD) && i_req.sat
    && i_req.data[15] |=> o_rsp.data == 64'h0)
    else $error("negative not clamped to zero");
  chk_trunc_low: assert property (is_op(FMT_D, FMT_UB) && !i_req.sat
    |=> o_rsp.data[7:0] == prev_r.data[7:0])
    else $error("truncation wrong");
  chk_df_denorm: assert property (is_op(FMT_DF, FMT_F)
    && i_req.data[62:52] == 11'h000
    |=> o_rsp.data[31:0] == {prev_r.data[63], 31'h0})
    else $error("double denormal not flushed");
  chk_df_finite: assert property (is_op(FMT_DF, FMT_F)
    && i_req.data[62:52] != 11'h7FF |=> o_rsp.data[30:23] != 8'hFF)
    else $error("finite double became special");
  chk_sf_inf: assert property (is_op(FMT_F, FMT_DF)
    && i_req.data[30:0] == 31'h7F80_0000
    |=> o_rsp.data == {prev_r.data[31], 63'h7FF0_0000_0000_0000})
    else $error("single infinity not kept");

  cov_sat: cover property (i_req.valid && i_req.sat ##1 o_rsp.valid);
  cov_df_sf: cover property (is_op(FMT_DF, FMT_F) ##1 o_rsp.valid);
  cov_sf_df: cover property (is_op(FMT_F, FMT_DF) ##1 o_rsp.valid);
endmodule : nfc_converter_assertions

bind nfc_converter nfc_converter_assertions nfc_converter_assertions_i
(
  .i_clock (i_clock),
  .i_rst_n (i_rst_n),
  .i_req   (i_req),
  .o_rsp   (o_rsp)
);

// >>> tb/nfc_issue_model.sv
`timescale 1ns/100ps

module nfc_issue_model
  import nfc_pkg::*;
(
  // Command from the bench
  input  wire logic        i_send,
  input  wire nfc_fmt_t    i_src_fmt,
  input  wire nfc_fmt_t    i_dst_fmt,
  input  wire logic        i_sat,
  input  wire logic [63:0] i_data,
  // Request towards the converter
  output nfc_req_t         o_req
);
  // =========================================================================
  // Issue
  // =========================================================================
  // Idle cycles carry inverted junk so stale data is never mistaken for live
  always_comb
  begin
    o_req.valid   = i_send;
    o_req.src_fmt = i_src_fmt;
    o_req.dst_fmt = i_dst_fmt;
    o_req.sat     = i_sat;
    o_req.data    = i_send ? i_data : ~i_data;
  end
endmodule : nfc_issue_model

// >>> tb/tb_nfc_converter.sv
`timescale 1ns/100ps

module tb_nfc_converter
  import nfc_pkg::*;
;
  typedef struct packed
  {
    nfc_fmt_t    src;
    nfc_fmt_t    dst;
    logic        sat;
    logic [63:0] din;
    logic [63:0] want;
  } nfc_row_t;

  localparam int NROWS = 31;
  // =========================================================================
  // Ordinary cases
  // =========================================================================
  nfc_row_t rows [NROWS] = '{
    '{FMT_UB, FMT_UW, 1'b0, 64'h00FF, 64'h00FF},
    '{FMT_UB, FMT_D, 1'b0, 64'h0080, 64'h0080},
    '{FMT_UB, FMT_B, 1'b0, 64'h00FF, '1},
    '{FMT_UB, FMT_B, 1'b1, 64'h00FF, 64'h007F},
    '{FMT_UD, FMT_D, 1'b1, 64'hFFFF_FFFF, 64'h7FFF_FFFF},
    '{FMT_B, FMT_W, 1'b0, 64'h0080, 64'hFFFF_FFFF_FFFF_FF80},
    '{FMT_W, FMT_UD, 1'b0, 64'h8000, 64'hFFFF_8000},
    '{FMT_W, FMT_UD, 1'b1, 64'h8000, 64'h0},
    '{FMT_D, FMT_UB, 1'b0, 64'h1234_5678, 64'h0078},
    '{FMT_UW, FMT_B, 1'b0, 64'h1280, 64'hFFFF_FFFF_FFFF_FF80},
    '{FMT_D, FMT_B, 1'b1, 64'h1234_5678, 64'h007F},
    '{FMT_D, FMT_B, 1'b1, 64'hFFFF_0000, 64'hFFFF_FFFF_FFFF_FF80},
    '{FMT_UQ, FMT_UD, 1'b1, 64'h1_0000_0000, 64'hFFFF_FFFF},
    '{FMT_Q, FMT_UB, 1'b1, 64'h8000_0000_0000_0000, 64'h0},
    '{FMT_D, FMT_F, 1'b0, 64'h00FF_FFFF, 64'h4B7F_FFFF},
    '{FMT_D, FMT_F, 1'b0, 64'hFFFF_FFFF, 64'hBF80_0000},
    '{FMT_D, FMT_F, 1'b0, 64'h0100_0001, 64'h4B80_0000},
    '{FMT_D, FMT_F, 1'b0, 64'h0100_0003, 64'h4B80_0002},
    '{FMT_DF, FMT_F, 1'b0, 64'hFFF0_0000_0000_0000, 64'hFF80_0000},
    '{FMT_DF, FMT_F, 1'b0, 64'h8000_0000_0000_0001, 64'h8000_0000},
    '{FMT_DF, FMT_F, 1'b0, 64'h7FF8_0000_0000_0000, 64'h7FC0_0000},
    '{FMT_DF, FMT_F, 1'b0, 64'h3FF0_0000_3000_0000, 64'h3F80_0002},
    '{FMT_DF, FMT_F, 1'b0, 64'h3FF0_0000_1000_0000, 64'h3F80_0000},
    '{FMT_DF, FMT_F, 1'b0, 64'h3370_0000_0000_0000, 64'h0},
    '{FMT_DF, FMT_F, 1'b0, 64'h3800_0000_0000_0000, 64'h0040_0000},
    '{FMT_DF, FMT_F, 1'b0, 64'h47F0_0000_0000_0000, 64'h7F7F_FFFF},
    '{FMT_DF, FMT_F, 1'b0, 64'h47EF_FFFF_FFFF_FFFF, 64'h7F7F_FFFF},
    '{FMT_F, FMT_DF, 1'b0, 64'h0001, 64'h36A0_0000_0000_0000},
    '{FMT_F, FMT_DF, 1'b0, 64'h8000_0003, 64'hB6B8_0000_0000_0000},
    '{FMT_F, FMT_DF, 1'b0, 64'hFF80_0000, 64'hFFF0_0000_0000_0000},
    '{FMT_F, FMT_DF, 1'b0, 64'h3F80_0000, 64'h3FF0_0000_0000_0000}
  };

  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        send  = 1'b0;
  nfc_fmt_t    src   = FMT_UB;
  nfc_fmt_t    dst   = FMT_UB;
  logic        sat   = 1'b0;
  logic [63:0] din   = 64'h0;
  nfc_req_t    req;
  nfc_rsp_t    rsp;
  int          num_errors   = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  always #20 clock = ~clock;

  nfc_issue_model nfc_issue_model_i
  (
    .i_send    (send),
    .i_src_fmt (src),
    .i_dst_fmt (dst),
    .i_sat     (sat),
    .i_data    (din),
    .o_req     (req)
  );

  nfc_converter nfc_converter_i
  (
    .i_clock (clock),
    .i_rst_n (rst_n),
    .i_req   (req),
    .o_rsp   (rsp)
  );

  // =========================================================================
  // Tasks
  // =========================================================================
  task automatic check(input logic [65:0] seen, input logic [65:0] want);
    total_checks++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 200)
    begin
      num_errors++;
      finish_test();
    end
  end

  // =========================================================================
  // Sequence
  // =========================================================================
  initial
  begin
    repeat (6) @(negedge clock);
    rst_n <= 1'b1;
    // Back to back: each negedge checks the previous row and drives the next
    for (int k = 0; k <= NROWS; k++)
    begin
      if (k > 0)
        check(rsp, {2'b10, rows[k-1].want});
      send <= (k < NROWS);
      src  <= rows[k % NROWS].src;
      dst  <= rows[k % NROWS].dst;
      sat  <= rows[k % NROWS].sat;
      din  <= rows[k % NROWS].din;
      @(negedge clock);
    end
    check({65'h0, rsp.valid}, 66'h0);
    // Float to integer is outside this block and must be flagged
    send <= 1'b1;
    src  <= FMT_F;
    dst  <= FMT_UD;
    din  <= 64'h3F80_0000;
    @(negedge clock);
    check(rsp, {2'b11, 64'h0});
    // Reset in mid-run clears the result at once
    rst_n <= 1'b0;
    #1;
    check(rsp, RSP_RESET);
    @(negedge clock);
    rst_n <= 1'b1;
    send  <= 1'b0;
    @(negedge clock);
    check({65'h0, rsp.valid}, 66'h0);
    finish_test();
  end
endmodule : tb_nfc_converter
